// ---- serial_pkg.sv ----
// constants for the serial slave peripheral: register map, field layout, reset values, timing
// assumes an APB slave with 32-bit data and a 125 MHz peripheral clock
//
// Overview of operation
// - select 00 in slave: underrun sets no TX flag
// - byte write to lane 0 also hits lane 1
// - byte write to lane 1 is discarded
// - framed clear of underrun reads clear before engine ready
// - slave sleep entry after transfer may raise false wake
package serial_pkg;
    // ***************************************************
    // register offsets (byte addresses)
    // ***************************************************
    localparam logic [7:0] OFF_CTRL     = 8'h00; // serial_control_word
    localparam logic [7:0] OFF_STAT     = 8'h04; // serial_status_word
    localparam logic [7:0] OFF_TXBUF    = 8'h08;
    localparam logic [7:0] OFF_RXBUF    = 8'h0c;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h10;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h14;

    // ***************************************************
    // field positions
    // ***************************************************
    localparam int CTRL_EN       = 0;
    localparam int CTRL_FRAMED   = 1;
    localparam int CTRL_TXSEL    = 2; // two bits, 3:2
    localparam int CTRL_IE       = 4;
    localparam int CTRL_SLEEP    = 5;
    localparam int STAT_RX_FULL  = 0;
    localparam int STAT_TX_EMPTY = 1;
    localparam int STAT_UNDERRUN = 8;
    localparam int STAT_READY    = 9;
    localparam int STAT_BUSY     = 11;
    localparam int IRQ_TX        = 0;
    localparam int IRQ_RX        = 1;
    localparam int IRQ_UR        = 2;
    localparam int IRQ_WAKE      = 3;
    localparam int IRQ_W         = 4;

    // ***************************************************
    // reset values and timing
    // ***************************************************
    localparam logic [5:0]       CTRL_RESET     = 6'h00;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 4'h0;
    localparam int CLK_PERIOD_NS    = 8;
    localparam int BIT_TIME_NS      = 160;
    localparam int RECOVER_BITS     = 4;
    localparam int RECOVER_CYCLES   = (RECOVER_BITS * BIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [1:0]
    {
        ST_IDLE    = 2'b00,
        ST_XFER    = 2'b01,
        ST_RECOVER = 2'b10
    } link_state_e;
endpackage

// ---- sync_if.sv ----
// carries raw pin levels into the synchroniser and the settled levels back
// assumes one clock domain on the reading side
`timescale 1ns/1ps
`default_nettype none
interface sync_if #(parameter int W = 3);
    logic [W-1:0] raw;
    logic [W-1:0] synced;
    modport pins (output raw, input synced);
    modport sync (input raw, output synced);
endinterface
`default_nettype wire

// ---- sync2.sv ----
// two-flop synchroniser for a group of asynchronous pins
// assumes the pins are independent levels; no bus coherency is promised
`timescale 1ns/1ps
`default_nettype none
module sync2
(
    input  wire logic clk,
    input  wire logic rst_n,
    sync_if.sync      sp
);
    logic [$bits(sp.raw)-1:0] meta_reg;
    logic [$bits(sp.raw)-1:0] hold_reg;

    // first stage feeds only the second stage
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_reg <= '0;
            hold_reg <= '0;
        end
        else
        begin
            meta_reg <= sp.raw;
            hold_reg <= meta_reg;
        end
    end

    assign sp.synced = hold_reg;
endmodule
`default_nettype wire

// ---- serial_slave.sv ----
// serial slave peripheral with APB register access and frame or select driven transfers
// assumes an external master drives sck, frame/select and mosi; all pins are asynchronous
//
// The implementer's own choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
module serial_slave
    import serial_pkg::*;
#(
    parameter int FRAME_BITS = 8
)
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             irq,
    input  wire logic        sck,
    input  wire logic        frm,
    input  wire logic        mosi,
    output logic             miso,
    output logic             miso_oe
);
    // ***************************************************
    // parameter check
    // ***************************************************
    if (FRAME_BITS < 2 || FRAME_BITS > 16)
    begin : g_bad_width
        $error("FRAME_BITS must lie in 2..16");
    end

    localparam int CNT_W = $clog2(FRAME_BITS + 1);
    localparam int REC_W = $clog2(RECOVER_CYCLES + 1);

    // ***************************************************
    // pin synchronisation and edge detection
    // ***************************************************
    sync_if #(.W(3)) pin_s ();
    assign pin_s.raw = {frm, sck, mosi};
    sync2 u_sync (.clk(clk), .rst_n(rst_n), .sp(pin_s));

    logic frm_s, sck_s, mosi_s, frm_d_reg, sck_d_reg;
    assign frm_s  = pin_s.synced[2];
    assign sck_s  = pin_s.synced[1];
    assign mosi_s = pin_s.synced[0];

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            frm_d_reg <= 1'b1;
            sck_d_reg <= 1'b0;
        end
        else
        begin
            frm_d_reg <= frm_s;
            sck_d_reg <= sck_s;
        end
    end

    // ***************************************************
    // register state
    // ***************************************************
    logic [5:0]            ctrl_reg;
    logic [FRAME_BITS-1:0] tx_buf_reg, rx_buf_reg, shift_reg;
    logic                  tx_full_reg, rx_full_reg, underrun_reg, sleep_d_reg, done_since_reg;
    logic [IRQ_W-1:0]      irq_stat_reg, irq_mask_reg;
    link_state_e           state_reg;
    logic [CNT_W-1:0]      bit_cnt_reg;
    logic [REC_W-1:0]      rec_cnt_reg;

    wire       framed   = ctrl_reg[CTRL_FRAMED];
    wire [1:0] tx_irq_select = ctrl_reg[CTRL_TXSEL +: 2];

    // ***************************************************
    // bus decode
    // ***************************************************
    wire acc      = psel & penable & pready;   // completing access edge
    wire wr       = acc & pwrite;
    wire rd       = acc & ~pwrite;
    wire hit_ctrl = paddr == OFF_CTRL;
    wire hit_stat = paddr == OFF_STAT;
    wire hit_tx   = paddr == OFF_TXBUF;
    wire hit_rx   = paddr == OFF_RXBUF;
    wire hit_is   = paddr == OFF_IRQ_STAT;
    wire hit_im   = paddr == OFF_IRQ_MASK;
    wire mapped   = hit_ctrl | hit_stat | hit_tx | hit_rx | hit_is | hit_im;

    // status word byte lanes: lone lane 0 strobe also writes lane 1, lone lane 1 strobe dropped
    wire        stat_lane0 = pstrb == 4'b0001;
    wire        stat_lane1_ok = stat_lane0 | (pstrb[1] & pstrb != 4'b0010);
    wire [15:0] stat_wdata = stat_lane0 ? {pwdata[7:0], pwdata[7:0]} : pwdata[15:0];
    wire        ur_clear   = wr & hit_stat & stat_lane1_ok & stat_wdata[STAT_UNDERRUN];

    // ***************************************************
    // link events
    // ***************************************************
    wire en         = ctrl_reg[CTRL_EN];
    wire start_ok   = en & (state_reg == ST_IDLE);
    wire frame_start = start_ok & (framed ? (frm_s & ~frm_d_reg) : (~frm_s & frm_d_reg));
    wire desel      = ~framed & frm_s & (state_reg == ST_XFER);
    wire sck_rise   = (state_reg == ST_XFER) & sck_s & ~sck_d_reg;
    wire sck_fall   = (state_reg == ST_XFER) & ~sck_s & sck_d_reg;
    wire last_bit   = bit_cnt_reg == CNT_W'(FRAME_BITS - 1);
    wire done_evt   = sck_rise & last_bit;
    wire reload     = done_evt & ~framed & ~frm_s;           // select held: next word follows
    wire load_evt   = frame_start | reload;
    wire tx_load    = load_evt & tx_full_reg;
    wire ur_evt     = load_evt & ~tx_full_reg;
    wire sleep_evt  = ctrl_reg[CTRL_SLEEP] & ~sleep_d_reg;
    // false wake on every sleep entry with IE set once any transfer finished since enable
    wire wake_evt   = sleep_evt & ctrl_reg[CTRL_IE] & done_since_reg;

    // select 00 reports only finished words; underrun never reaches the TX flag then
    wire tx_evt = (tx_irq_select == 2'b00) ? done_evt : (tx_load | ur_evt);
    wire [IRQ_W-1:0] irq_set = {wake_evt, ur_evt, done_evt, tx_evt};
    wire [IRQ_W-1:0] irq_clr = (wr & hit_is) ? pwdata[IRQ_W-1:0] : '0;

    // ***************************************************
    // bus answer: one wait state, registered data
    // ***************************************************
    logic [31:0] rdata;
    always_comb
    begin
        rdata = 32'h0;
        if (hit_ctrl) rdata[5:0] = ctrl_reg;
        if (hit_stat)
        begin
            rdata[STAT_RX_FULL]  = rx_full_reg;
            rdata[STAT_TX_EMPTY] = ~tx_full_reg;
            rdata[STAT_UNDERRUN] = underrun_reg;
            rdata[STAT_READY]    = state_reg != ST_RECOVER;
            rdata[STAT_BUSY]     = state_reg == ST_XFER;
        end
        if (hit_rx) rdata[FRAME_BITS-1:0] = rx_buf_reg;
        if (hit_is) rdata[IRQ_W-1:0] = irq_stat_reg;
        if (hit_im) rdata[IRQ_W-1:0] = irq_mask_reg;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pready  <= 1'b0;
            prdata  <= 32'h0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= psel & penable & ~pready;
            prdata  <= (psel & penable & ~pready) ? rdata : 32'h0;
            pslverr <= psel & penable & ~pready & ~mapped;
        end
    end

    // ***************************************************
    // software registers and sticky flags (set beats clear)
    // ***************************************************
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl_reg       <= CTRL_RESET;
            irq_mask_reg   <= IRQ_MASK_RESET;
            irq_stat_reg   <= '0;
            tx_buf_reg     <= '0;
            tx_full_reg    <= 1'b0;
            rx_buf_reg     <= '0;
            rx_full_reg    <= 1'b0;
            underrun_reg   <= 1'b0;
            sleep_d_reg    <= 1'b0;
            done_since_reg <= 1'b0;
            irq            <= 1'b0;
        end
        else
        begin
            if (wr & hit_ctrl) ctrl_reg <= pwdata[5:0];
            if (wr & hit_im) irq_mask_reg <= pwdata[IRQ_W-1:0];
            irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_set;
            if (wr & hit_tx) tx_buf_reg <= pwdata[FRAME_BITS-1:0];
            tx_full_reg  <= (wr & hit_tx) | (tx_full_reg & ~tx_load);
            if (done_evt) rx_buf_reg <= {shift_reg[FRAME_BITS-2:0], mosi_s};
            rx_full_reg  <= done_evt | (rx_full_reg & ~(rd & hit_rx));
            // flag reads clear at once even when the engine still recovers
            underrun_reg <= ur_evt | (underrun_reg & ~ur_clear);
            sleep_d_reg  <= ctrl_reg[CTRL_SLEEP];
            done_since_reg <= (done_since_reg & en) | done_evt;
            irq <= |((irq_stat_reg & ~irq_clr | irq_set) & irq_mask_reg);
        end
    end

    // ***************************************************
    // transfer engine
    // ***************************************************
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg   <= ST_IDLE;
            bit_cnt_reg <= '0;
            rec_cnt_reg <= '0;
            shift_reg   <= '0;
            miso        <= 1'b0;
            miso_oe     <= 1'b0;
        end
        else
        begin
            case (state_reg)
                ST_IDLE:
                begin
                    miso_oe <= 1'b0;
                    if (ur_clear & framed & en)
                    begin
                        // engine lags the flag by four bit times
                        state_reg   <= ST_RECOVER;
                        rec_cnt_reg <= REC_W'(RECOVER_CYCLES);
                    end
                    else if (frame_start)
                    begin
                        state_reg   <= ST_XFER;
                        bit_cnt_reg <= '0;
                        shift_reg   <= tx_full_reg ? tx_buf_reg : '0;
                        miso        <= tx_full_reg & tx_buf_reg[FRAME_BITS-1];
                        miso_oe     <= 1'b1;
                    end
                end
                ST_XFER:
                begin
                    if (~en | desel)
                    begin
                        state_reg <= ST_IDLE;
                        miso_oe   <= 1'b0;
                    end
                    else if (reload)
                    begin
                        bit_cnt_reg <= '0;
                        shift_reg   <= tx_full_reg ? tx_buf_reg : '0;
                        miso        <= tx_full_reg & tx_buf_reg[FRAME_BITS-1];
                    end
                    else if (done_evt)
                    begin
                        state_reg <= framed ? ST_IDLE : ST_XFER;
                        miso_oe   <= ~framed;
                    end
                    else if (sck_rise)
                    begin
                        bit_cnt_reg <= bit_cnt_reg + CNT_W'(1);
                        shift_reg   <= {shift_reg[FRAME_BITS-2:0], mosi_s};
                    end
                    else if (sck_fall)
                    begin
                        miso <= shift_reg[FRAME_BITS-1];
                    end
                end
                ST_RECOVER:
                begin
                    // frames arriving here are ignored; software is expected to wait
                    rec_cnt_reg <= rec_cnt_reg - REC_W'(1);
                    if (rec_cnt_reg == REC_W'(1)) state_reg <= ST_IDLE;
                end
                default:
                begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// ---- serial_slave_checker.sv ----
// checker: APB handshake and underrun recovery at the serial slave ports
// assumes one clock domain, rst_n async low
`timescale 1ns/1ps
`default_nettype none
module serial_slave_checker
    import serial_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // ****************
    // helper logic
    // ****************
    // a lane-1-only write never clears; lane 0 alone clears through bit 0
    wire        done = psel && penable && pready;
    wire        clr  = done && pwrite && paddr == OFF_STAT && pstrb[0] && (pstrb[1] ? pwdata[8] : pwdata[0]);
    wire        rds  = done && !pwrite && paddr == OFF_STAT;
    logic       frm_reg;
    logic [7:0] since_reg;
    // saturating count, so an old clear cannot match again
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            frm_reg   <= 1'b0;
            since_reg <= 8'hff;
        end
        else
        begin
            if (done && pwrite && paddr == OFF_CTRL)
                frm_reg <= pwdata[CTRL_FRAMED];
            if (clr && frm_reg)
                since_reg <= 8'h00;
            else if (since_reg != 8'hff)
                since_reg <= since_reg + 8'h01;
        end
    end
    sequence setup_s;
        psel && !penable;
    endsequence
    sequence answer_s;
        !pready ##1 pready;
    endsequence
    chk_wait_state: assert property (setup_s |=> answer_s)
        else $error("pready not after one wait state");
    chk_ready_single: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    chk_err_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    chk_rdata_quiet: assert property (!pready |-> prdata == 32'h0)
        else $error("prdata not zero outside answer");
    chk_unmapped_err: assert property (done && paddr > OFF_IRQ_MASK |-> pslverr)
        else $error("unmapped address not refused");
    chk_recovery_busy: assert property (rds && since_reg < 8'd60 |-> prdata[9:8] == 2'b00)
        else $error("status not clear and busy in recovery");
endmodule
bind serial_slave serial_slave_checker i_serial_slave_checker
(
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr)
);
`default_nettype wire

// ---- serial_master_model.sv ----
// external framed master: frame pulse, 160 ns link clock, one byte each way
// assumes frames are started by the bench, one at a time
`timescale 1ns/1ps
`default_nettype none
module serial_master_model
(
    output logic      sck,
    output logic      frm,
    output logic      mosi,
    input  wire logic miso
);
    // idle: clock parked low, no frame
    initial
    begin
        sck  = 1'b0;
        frm  = 1'b0;
        mosi = 1'b0;
    end
    // msb first; the 3 ns skew keeps link edges off the bench clock edges
    task automatic frame(input logic [7:0] tx, output logic [7:0] rx);
        rx = 8'h00;
        #3;
        frm = 1'b1;
        #80;
        frm = 1'b0;
        #80;
        for (int i = 7; i >= 0; i--)
        begin
            mosi = tx[i];
            #80;
            sck = 1'b1;
            rx[i] = miso;
            #80;
            sck = 1'b0;
        end
        mosi = ~mosi; // released line shows no stale bit
    endtask
    // select released: a high level ends a select-driven word stream
    task automatic release_sel;
        #3;
        frm = 1'b1;
        #80;
    endtask
endmodule
`default_nettype wire

// ---- spi_slave_frame_quirks_bench.sv ----
// bench for serial_slave: APB tasks, framed link traffic, interrupts
// assumes serial_master_model and the bound checker
`timescale 1ns/1ps
`default_nettype none
module spi_slave_frame_quirks_bench import serial_pkg::*;;
    localparam logic [31:0] UR  = 32'h1 << STAT_UNDERRUN;
    localparam logic [31:0] RDY = 32'h1 << STAT_READY;
    localparam logic [31:0] FR  = (32'h1 << CTRL_EN) | (32'h1 << CTRL_FRAMED);
    localparam logic [31:0] IE  = 32'h1 << CTRL_IE;
    localparam logic [31:0] SLP = 32'h1 << CTRL_SLEEP;
    logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, irq;
    logic        sck, frm, mosi, miso, miso_oe, err;
    logic [7:0]  paddr, rx;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  pstrb;
    int          bad_count, cmp_count, sel;
    // 125 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    serial_slave #(.FRAME_BITS(8)) i_serial_slave
    (
        .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .irq(irq), .sck(sck), .frm(frm), .mosi(mosi), .miso(miso), .miso_oe(miso_oe)
    );
    serial_master_model i_serial_master_model
    (
        .sck(sck), .frm(frm), .mosi(mosi), .miso(miso)
    );
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // one APB transfer, held until pready is sampled high
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d, input logic [3:0] s);
        int n;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        paddr   <= a;
        pwrite  <= w;
        pwdata  <= d;
        pstrb   <= s;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (n >= 20)
        begin
            bad_count++;
            final_report;
        end
    endtask
    task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(a, 1'b0, 32'h0, 4'h0);
        check(nm, rd & m, e);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(a, 1'b1, d, 4'hf);
    endtask
    // main sequence
    initial
    begin
        {psel, penable, pwrite, rst_n, paddr, pwdata, pstrb} = '0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        check("oe_idle", {31'h0, miso_oe}, 32'h0);
        rchk("ctrl", OFF_CTRL, 32'hffffffff, {26'h0, CTRL_RESET});
        rchk("mask", OFF_IRQ_MASK, 32'hf, {28'h0, IRQ_MASK_RESET});
        apb(8'h18, 1'b0, 32'h0, 4'h0);
        check("slverr", {31'h0, err}, 32'h1);
        wr(OFF_IRQ_MASK, 32'hf);
        // every select code, each frame clocked with an empty transmit buffer
        for (sel = 0; sel < 4; sel++)
        begin
            wr(OFF_CTRL, FR | (32'(sel) << CTRL_TXSEL));
            wr(OFF_IRQ_STAT, 32'hf);
            fork
                i_serial_master_model.frame(8'h5a ^ 8'(sel), rx);
                begin
                    repeat (75) @(posedge clk);
                    check("irq_mid", {31'h0, irq}, 32'h1);
                    check("oe_busy", {31'h0, miso_oe}, 32'h1);
                    rchk("tx_irq", OFF_IRQ_STAT, 32'h5, (sel == 0) ? 32'h4 : 32'h5);
                end
            join
            check("zeros_out", {24'h0, rx}, 32'h0);
            rchk("rxbuf", OFF_RXBUF, 32'hff, {24'h0, 8'h5a ^ 8'(sel)});
            rchk("ur_set", OFF_STAT, UR, UR);
            if (sel == 0)
            begin
                apb(OFF_STAT, 1'b1, UR, 4'b0010);
                rchk("lane1", OFF_STAT, UR, UR);
                apb(OFF_STAT, 1'b1, 32'h1, 4'b0001);
            end
            else
                wr(OFF_STAT, UR);
            rchk("ur_clr", OFF_STAT, UR | RDY, 32'h0);
            repeat (RECOVER_CYCLES) @(posedge clk);
            rchk("ready", OFF_STAT, RDY, RDY);
        end
        // a clear after a clocked frame starts recovery; the frame inside it is ignored
        // then a loaded buffer leaves no underrun
        i_serial_master_model.frame(8'h11, rx);
        rchk("rx_drain", OFF_RXBUF, 32'hff, 32'h11);
        wr(OFF_STAT, UR);
        i_serial_master_model.frame(8'h22, rx);
        rchk("rx_refused", OFF_STAT, 32'h1 << STAT_RX_FULL, 32'h0);
        wr(OFF_TXBUF, 32'h3c);
        i_serial_master_model.frame(8'hc3, rx);
        check("miso_byte", {24'h0, rx}, 32'h3c);
        rchk("no_ur", OFF_STAT, UR, 32'h0);
        // select-driven mode: select held low reloads the next word, and the buffer is empty then
        wr(OFF_CTRL, 32'h1 << CTRL_EN);
        wr(OFF_TXBUF, 32'h96);
        i_serial_master_model.frame(8'h69, rx);
        check("sel_miso", {24'h0, rx}, 32'h96);
        check("oe_sel", {31'h0, miso_oe}, 32'h1);
        rchk("sel_busy", OFF_STAT, (32'h1 << STAT_BUSY) | UR, (32'h1 << STAT_BUSY) | UR);
        i_serial_master_model.release_sel;
        rchk("sel_idle", OFF_STAT, 32'h1 << STAT_BUSY, 32'h0);
        check("oe_off", {31'h0, miso_oe}, 32'h0);
        rchk("sel_rx", OFF_RXBUF, 32'hff, 32'h69);
        // wake flag recurs on each sleep entry; observed, never used to wake
        wr(OFF_IRQ_STAT, 32'hf);
        for (int k = 0; k < 3; k++)
        begin
            wr(OFF_CTRL, FR | IE);
            wr(OFF_CTRL, FR | IE | SLP);
            rchk("wake", OFF_IRQ_STAT, 32'h8, 32'h8);
            if (k < 2)
                wr(OFF_IRQ_STAT, 32'h8);
        end
        check("irq_on", {31'h0, irq}, 32'h1);
        wr(OFF_IRQ_MASK, 32'h0);
        repeat (2) @(posedge clk);
        check("irq_masked", {31'h0, irq}, 32'h0);
        wr(OFF_IRQ_STAT, 32'hf);
        rchk("wake_clr", OFF_IRQ_STAT, 32'hf, 32'h0);
        final_report;
    end
endmodule
`default_nettype wire
